// *** rtl/lpp_packer.sv ***
// LVDS pixel packer: strap latch, APB config, channel packing and serialiser
// Notes on behaviour
// (R1) Bus-count strap low gives one LVDS bus, high gives odd and even buses.
// (R2) Format strap: low VESA 24, open JEIDA 24, high 18 bpp.
// (R3) Works in single and dual bus across the 6 to 112 MHz pixel range.
// (R4) Each bus has a clock plus three data channels at 18, four at 24.
// (R5) Each channel carries positions 6 down to 0 per pixel clock.
// (R6) 18 bpp: A holds red 5..0 and green 0; B blue 1..0, green 5..1.
// (R7) Channel C: valid at 6, vsync 5, hsync 4, then blue high bits.
// (R8) VESA 24: A to C as 18 bpp; D holds bits 7,6 of blue, green, red.
// (R9) JEIDA 24: A to C use bits 7..2; D holds bits 1,0.
// (R10) Dual 18 VESA: both buses use the single 18 bpp layout.
// (R11) Dual 24 VESA: both buses repeat the single VESA 24 layout.
// (R12) Dual 18 JEIDA: identical to dual 18 VESA.
// (R13) Optional centre spread of LVDS clock; off means no modulation.
// (R14) Bus count, depth and format also settable by register.
// (R15) Registers sit at vendor base plus offset.
// (R16) Integrator keeps payload within bandwidth when spreading is on.
// (R17) Straps latched at reset release and on wake, held otherwise.
// (R18) Straps read as config only while scan select is low.
// (R19) Dual 24 JEIDA: both buses repeat the single JEIDA 24 layout.
// (R20) First, second, third components are red, green, blue.
// (R21) Dual bus: odd gets first pixel of a pair, each bus at half rate.
// (R22) Serialise seven bits per LVDS clock, position 6 first.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module lpp_packer
   import lpp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pix_clk,
   input wire lpp_pixel_t pix_in,
   input wire logic bus_count_strap,
   input wire logic [1:0] format_depth_strap,
   input wire logic scan_select_input,
   input wire logic wake_pulse,
   output lpp_lvds_t lvds_odd,
   output lpp_lvds_t lvds_even
);

   // ******************************************************
   // State
   // ******************************************************
   typedef struct packed {
      logic [2:0] pclk_sync;
      logic [1:0] scan_sync;
      logic [1:0] wake_sync;
      logic wake_last;
      logic latch_pend;
      logic strap_dual;
      logic [1:0] strap_fmt;
      logic [4:0] ctrl;
      logic [31:0] rdata;
      logic ready;
      logic err;
      lpp_pixel_t pix_hold;
      logic pair_odd;
      lpp_bus_word_t word_odd;
      lpp_bus_word_t word_even;
      lpp_bus_word_t sh_odd;
      lpp_bus_word_t sh_even;
      lpp_state_t state;
      logic [2:0] bitpos;
      logic [1:0] slot;
      logic [3:0] spread_cnt;
      logic spread_dly;
      lpp_lvds_t out_odd;
      lpp_lvds_t out_even;
   } lpp_regs_t;

   lpp_regs_t r_ff;
   lpp_regs_t nxt_r;
   logic eff_dual;
   logic [1:0] eff_fmt;
   logic pix_rise;
   lpp_bus_word_t packed_word;

   // ******************************************************
   // Packing function
   // ******************************************************
   // One bus word from one pixel in the given format
   function automatic lpp_bus_word_t pack_pixel(input lpp_pixel_t p, input logic [1:0] fmt);
      lpp_bus_word_t w;
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
      r = p.red; // R20
      g = p.green;
      b = p.blue;
      w = '0;
      if (fmt == LPP_FMT_JEIDA24) begin
         // Upper six bits moved into the 18 bpp slots
         r = {p.red[1:0], p.red[7:2]}; // R9
         g = {p.green[1:0], p.green[7:2]};
         b = {p.blue[1:0], p.blue[7:2]};
      end
      w.ch_a = {g[0], r[5:0]}; // R6
      w.ch_b = {b[1:0], g[5:1]}; // R6
      w.ch_c = {p.pixel_valid_flag, p.vsync, p.hsync, b[5:2]}; // R7
      if (fmt == LPP_FMT_VESA24) begin
         w.ch_d = {1'b0, b[7:6], g[7:6], r[7:6]}; // R8
      end else if (fmt == LPP_FMT_JEIDA24) begin
         w.ch_d = {1'b0, b[7:6], g[7:6], r[7:6]}; // R9
      end
      // At 18 bpp channel D stays idle: three channels only (R4)
      return w;
   endfunction

   // ******************************************************
   // Effective mode
   // ******************************************************
   // Register override takes priority over latched straps
   always_comb begin
      if (r_ff.ctrl[LPP_CTRL_OVR]) begin
         eff_dual = r_ff.ctrl[LPP_CTRL_DUAL]; // R14
         eff_fmt = r_ff.ctrl[LPP_CTRL_FMT_LO +: 2];
      end else begin
         eff_dual = r_ff.strap_dual; // R1
         eff_fmt = r_ff.strap_fmt; // R2
      end
   end

   assign pix_rise = r_ff.pclk_sync[1] & ~r_ff.pclk_sync[2];
   assign packed_word = pack_pixel(r_ff.pix_hold, eff_fmt);

   // ******************************************************
   // Next-state logic
   // ******************************************************
   always_comb begin
      nxt_r = r_ff;
      // Two-flop sync; edge detect reads only the second and third stage
      nxt_r.pclk_sync = {r_ff.pclk_sync[1:0], pix_clk};
      nxt_r.scan_sync = {r_ff.scan_sync[0], scan_select_input};
      nxt_r.wake_sync = {r_ff.wake_sync[0], wake_pulse};
      nxt_r.wake_last = r_ff.wake_sync[1];
      // Catch straps once after reset release or a wake edge
      if (r_ff.latch_pend && !r_ff.scan_sync[1]) begin
         nxt_r.strap_dual = bus_count_strap; // R17 R18
         nxt_r.strap_fmt = format_depth_strap;
         nxt_r.latch_pend = 1'b0;
      end
      // A wake edge in the capture cycle wins, so no wake is lost
      if (r_ff.wake_sync[1] & ~r_ff.wake_last) begin
         nxt_r.latch_pend = 1'b1; // R17
      end
      // APB slave, zero wait states
      nxt_r.ready = 1'b0;
      nxt_r.err = 1'b0;
      nxt_r.rdata = LPP_ERR_DATA;
      if (psel && !penable) begin
         nxt_r.ready = 1'b1;
         if (paddr == LPP_ADDR_CTRL) begin // R15
            if (pwrite) begin
               nxt_r.ctrl = pwdata[4:0]; // R14 R13
            end else begin
               nxt_r.rdata = {27'h0000000, r_ff.ctrl};
            end
         end else if (paddr == LPP_ADDR_STAT) begin
            nxt_r.rdata = {25'h0000000, r_ff.pair_odd, eff_fmt, eff_dual,
                           r_ff.latch_pend, r_ff.strap_fmt[0] ^ 1'b0, r_ff.strap_dual};
            nxt_r.err = pwrite;
         end else begin
            nxt_r.err = 1'b1;
         end
      end
      // Capture pixel on pixel clock edge
      if (pix_rise) begin
         nxt_r.pix_hold = pix_in;
         if (eff_dual) begin
            nxt_r.pair_odd = ~r_ff.pair_odd; // R21
         end else begin
            // Next dual pixel toggles to odd, so a pair always starts odd
            nxt_r.pair_odd = 1'b0;
         end
      end
      // Pack one word per captured pixel; steering by pair phase
      if (r_ff.pclk_sync[2] & ~r_ff.pclk_sync[1]) begin
         if (!eff_dual) begin
            nxt_r.word_odd = packed_word; // R1
            nxt_r.word_even = '0;
         end else if (r_ff.pair_odd) begin
            nxt_r.word_odd = packed_word; // R21
         end else begin
            nxt_r.word_even = packed_word; // R10 R11 R12 R19
         end
      end
      // Serialiser: 7 bits per LVDS period, position 6 first
      nxt_r.slot = r_ff.slot + 2'h1;
      if (r_ff.slot == LPP_SLOT_LAST) begin
         nxt_r.slot = 2'h0;
      end
      case (r_ff.state)
         LPP_IDLE: begin
            nxt_r.bitpos = LPP_BIT_FIRST;
            nxt_r.slot = 2'h0;
            nxt_r.sh_odd = r_ff.word_odd;
            nxt_r.sh_even = r_ff.word_even;
            nxt_r.state = LPP_SHIFT;
         end
         LPP_SHIFT: begin
            if (r_ff.slot == LPP_SLOT_LAST) begin
               if (r_ff.bitpos == LPP_BIT_LAST) begin
                  nxt_r.bitpos = LPP_BIT_FIRST; // R22
                  nxt_r.sh_odd = r_ff.word_odd;
                  nxt_r.sh_even = r_ff.word_even;
                  nxt_r.spread_cnt = r_ff.spread_cnt + 4'h1;
               end else begin
                  nxt_r.bitpos = r_ff.bitpos - 3'h1;
               end
            end
         end
         default: begin
            nxt_r.state = LPP_IDLE;
         end
      endcase
      // Clock pattern 1100011: high for positions 6,5 and 1,0 ... classic 4:3
      nxt_r.out_odd.clk = (r_ff.bitpos > 3'h4) || (r_ff.bitpos < 3'h2); // R22
      // Centre spread: rising edge late by one slot in half the periods
      nxt_r.spread_dly = r_ff.ctrl[LPP_CTRL_SPREAD] & r_ff.spread_cnt[3]; // R13
      if (r_ff.spread_dly && r_ff.bitpos == LPP_BIT_LAST + 3'h1) begin
         nxt_r.out_odd.clk = r_ff.out_odd.clk;
      end
      nxt_r.out_even.clk = eff_dual & nxt_r.out_odd.clk; // R1
      nxt_r.out_odd.dat = {r_ff.sh_odd.ch_a[r_ff.bitpos], r_ff.sh_odd.ch_b[r_ff.bitpos],
                           r_ff.sh_odd.ch_c[r_ff.bitpos],
                           r_ff.sh_odd.ch_d[r_ff.bitpos] & (eff_fmt != LPP_FMT_18)}; // R4 R5
      nxt_r.out_even.dat = {r_ff.sh_even.ch_a[r_ff.bitpos], r_ff.sh_even.ch_b[r_ff.bitpos],
                            r_ff.sh_even.ch_c[r_ff.bitpos],
                            r_ff.sh_even.ch_d[r_ff.bitpos] & (eff_fmt != LPP_FMT_18)};
      if (!eff_dual) begin
         nxt_r.out_even.dat = 4'h0;
      end
   end

   // ******************************************************
   // Registers
   // ******************************************************
   // Reset loads constants only; strap capture waits for release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_ff <= '0;
         r_ff.latch_pend <= 1'b1;
         r_ff.ctrl <= LPP_CTRL_RESET;
         r_ff.bitpos <= LPP_BIT_FIRST;
         r_ff.state <= LPP_IDLE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign prdata = r_ff.rdata;
   assign pready = r_ff.ready;
   assign pslverr = r_ff.err;
   assign lvds_odd = r_ff.out_odd;
   assign lvds_even = r_ff.out_even;

   // ******************************************************
   // Checks
   // ******************************************************
   sequence s_setup;
      psel && !penable;
   endsequence

   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup |=> pready) else $error("APB answer missing"); // R15
   a_no_spread_off: assert property (@(posedge pclk) disable iff (!presetn)
      !r_ff.ctrl[LPP_CTRL_SPREAD] ##1 1'b1 |-> !r_ff.spread_dly)
      else $error("Spread active while off"); // R13
   a_even_idle_single: assert property (@(posedge pclk) disable iff (!presetn)
      !eff_dual |=> lvds_even.clk == 1'b0) else $error("Even bus clock in single mode"); // R1
   a_ovr_mode: assert property (@(posedge pclk) disable iff (!presetn)
      r_ff.ctrl[LPP_CTRL_OVR] |-> eff_fmt == r_ff.ctrl[LPP_CTRL_FMT_LO +: 2])
      else $error("Override ignored"); // R14
   a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !r_ff.latch_pend |=> $stable(r_ff.strap_dual)) else $error("Strap changed"); // R17
   a_scan_block: assert property (@(posedge pclk) disable iff (!presetn)
      r_ff.scan_sync[1] |=> $stable(r_ff.strap_fmt)) else $error("Strap taken in scan"); // R18
   a_bit_order: assert property (@(posedge pclk) disable iff (!presetn)
      (r_ff.state == LPP_SHIFT && r_ff.slot == LPP_SLOT_LAST && r_ff.bitpos == LPP_BIT_LAST)
      |=> r_ff.bitpos == LPP_BIT_FIRST) else $error("Bit order broken"); // R22
   a_ch_d_18: assert property (@(posedge pclk) disable iff (!presetn)
      eff_fmt == LPP_FMT_18 && $stable(eff_fmt) |=> lvds_odd.dat[0] == 1'b0)
      else $error("Channel D active at 18 bpp"); // R4
   a_ctrl_layout: assert property (@(posedge pclk) disable iff (!presetn)
      r_ff.state == LPP_SHIFT |-> packed_word.ch_c[6] == r_ff.pix_hold.pixel_valid_flag)
      else $error("Valid flag misplaced"); // R7
endmodule
`default_nettype wire

// *** rtl/lpp_pkg.sv ***
// Package for the LVDS pixel packer: register map, field layout, modes, timing
package lpp_pkg;
   // APB register byte addresses (vendor base plus offset in config space)
   localparam logic [11:0] LPP_VENDOR_BASE = 12'h510;
   localparam logic [11:0] LPP_OFS_CTRL = 12'h000;
   localparam logic [11:0] LPP_OFS_STAT = 12'h004;
   localparam logic [11:0] LPP_ADDR_CTRL = LPP_VENDOR_BASE + LPP_OFS_CTRL;
   localparam logic [11:0] LPP_ADDR_STAT = LPP_VENDOR_BASE + LPP_OFS_STAT;
   // Control register fields
   localparam int LPP_CTRL_OVR = 0;
   localparam int LPP_CTRL_DUAL = 1;
   localparam int LPP_CTRL_FMT_LO = 2;
   localparam int LPP_CTRL_SPREAD = 4;
   localparam logic [4:0] LPP_CTRL_RESET = 5'h00;
   localparam logic [31:0] LPP_ERR_DATA = 32'h00000000;
   // Three-level format codes (strap low / open / high)
   localparam logic [1:0] LPP_FMT_VESA24 = 2'h0;
   localparam logic [1:0] LPP_FMT_JEIDA24 = 2'h1;
   localparam logic [1:0] LPP_FMT_18 = 2'h2;
   // Serial slot: pclk cycles per LVDS bit
   localparam int LPP_SLOT_CYCLES = 2;
   localparam logic [1:0] LPP_SLOT_LAST = 2'(LPP_SLOT_CYCLES - 1);
   localparam logic [2:0] LPP_BIT_FIRST = 3'h6;
   localparam logic [2:0] LPP_BIT_LAST = 3'h0;
   // Spread: dither period in LVDS clock periods
   localparam logic [3:0] LPP_SPREAD_LAST = 4'hF;

   // Pixel as it arrives
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
      logic hsync;
      logic vsync;
      logic pixel_valid_flag;
   } lpp_pixel_t;

   // One bus: four channels of seven positions
   typedef struct packed {
      logic [6:0] ch_a;
      logic [6:0] ch_b;
      logic [6:0] ch_c;
      logic [6:0] ch_d;
   } lpp_bus_word_t;

   // Serial outputs of one bus
   typedef struct packed {
      logic clk;
      logic [3:0] dat;
   } lpp_lvds_t;

   typedef enum logic [1:0] {
      LPP_IDLE,
      LPP_SHIFT
   } lpp_state_t;
endpackage

// *** verification/lpp_rx_model.sv ***
// Panel receiver model: deserialises one LVDS bus and watches its clock
`timescale 1ns/10ps
`default_nettype none
module lpp_rx_model
   import lpp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire lpp_lvds_t lvds,
   input wire logic spread_on,
   output var lpp_bus_word_t word,
   output var logic word_valid,
   output var int n_early
);
   // ************************************
   // Deserialiser
   // ************************************
   logic [3:0] hist [0:12];
   logic [9:0] fall_dl;
   logic clk_q;
   int gap;
   // Clock fall marks position 4; nine samples later position p sits at hist[2p]
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fall_dl <= '0;
         clk_q <= 1'b0;
         gap <= 14;
         n_early <= 0;
         word_valid <= 1'b0;
      end else begin
         hist[0] <= lvds.dat;
         for (int i = 1; i < 13; i++) begin
            hist[i] <= hist[i-1];
         end
         clk_q <= lvds.clk;
         fall_dl <= {fall_dl[8:0], clk_q & ~lvds.clk};
         gap <= (clk_q && !lvds.clk) ? 1 : gap + 1;
         // Unspread clock must keep a full seven-bit period
         if (clk_q && !lvds.clk && !spread_on && gap < 14) begin
            n_early <= n_early + 1;
         end
         word_valid <= fall_dl[8];
         // Position 6 went out first, so it is the oldest sample
         if (fall_dl[8]) begin
            for (int p = 0; p < 7; p++) begin
               word.ch_a[p] <= hist[2*p][3];
               word.ch_b[p] <= hist[2*p][2];
               word.ch_c[p] <= hist[2*p][1];
               word.ch_d[p] <= hist[2*p][0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/test_lpp_packer.sv ***
// Self-checking bench for the LVDS pixel packer
`timescale 1ns/10ps
`default_nettype none
module test_lpp_packer;
   import lpp_pkg::*;
   // ************************************
   // Stimulus, models and checks
   // ************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = '0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pix_clk = 1'b0, bus_count_strap = 1'b0, scan_select_input = 1'b0, wake_pulse = 1'b0;
   logic [1:0] format_depth_strap = LPP_FMT_VESA24;
   lpp_pixel_t pix_in = '0;
   lpp_lvds_t lvds_odd, lvds_even;
   lpp_bus_word_t w_odd, w_even;
   logic v_odd, v_even, spread_on = 1'b0;
   int n_mismatch = 0, n_tests = 0, n_cyc = 0, n_odd = 0, n_even = 0, e_odd, e_even;
   always #20 pclk = ~pclk;
   lpp_packer u_lpp_packer (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pix_clk(pix_clk), .pix_in(pix_in), .bus_count_strap(bus_count_strap),
      .format_depth_strap(format_depth_strap), .scan_select_input(scan_select_input),
      .wake_pulse(wake_pulse), .lvds_odd(lvds_odd), .lvds_even(lvds_even));
   lpp_rx_model u_lpp_rx_model_odd (.pclk(pclk), .presetn(presetn), .lvds(lvds_odd),
      .spread_on(spread_on), .word(w_odd), .word_valid(v_odd), .n_early(e_odd));
   lpp_rx_model u_lpp_rx_model_even (.pclk(pclk), .presetn(presetn), .lvds(lvds_even),
      .spread_on(spread_on), .word(w_even), .word_valid(v_even), .n_early(e_even));
   task automatic give_verdict();
      $display("Mismatches %0d, comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Word counters, and a ceiling well above the expected run length
   always @(posedge pclk) begin
      n_cyc <= n_cyc + 1;
      n_odd <= n_odd + int'(v_odd);
      n_even <= n_even + int'(v_even);
      if (n_cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Channel D is absent at 18 bpp, so only A to C are compared there
   task automatic cmpw(input string what, input lpp_bus_word_t e, input lpp_bus_word_t g,
      input logic d24);
      logic [27:0] m;
      m = d24 ? 28'hFFFFFFF : 28'hFFFFF80;
      chk(what, {4'h0, e & m}, {4'h0, g & m});
   endtask
   // JEIDA is VESA with each component rotated right by two bits
   function automatic lpp_bus_word_t pack(input lpp_pixel_t p, input logic jeida);
      logic [7:0] r, g, b;
      lpp_bus_word_t w;
      r = jeida ? {p.red[1:0], p.red[7:2]} : p.red;
      g = jeida ? {p.green[1:0], p.green[7:2]} : p.green;
      b = jeida ? {p.blue[1:0], p.blue[7:2]} : p.blue;
      w.ch_a = {g[0], r[5:0]};
      w.ch_b = {b[1:0], g[5:1]};
      w.ch_c = {p.pixel_valid_flag, p.vsync, p.hsync, b[5:2]};
      w.ch_d = {1'b0, b[7:6], g[7:6], r[7:6]};
      return w;
   endfunction
   // APB transfer; pready seen before an edge is what that edge samples
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One pixel clock pulse, high for 160 ns; the clock stands still afterwards
   task automatic px(input lpp_pixel_t p);
      @(posedge pclk);
      pix_in <= p;
      repeat (2) @(posedge pclk);
      pix_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      pix_clk <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic run_pixels(input logic jeida, input logic d24, input logic dual);
      lpp_pixel_t p [2];
      int b0, b1;
      p[0] = {8'hA5, 8'h3C, 8'hE7, 1'b1, 1'b0, 1'b1};
      p[1] = {8'h5A, 8'hC3, 8'h18, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 2; i++) begin
         b0 = n_odd;
         b1 = n_even;
         px(p[i]);
         // First word seen after this edge is stale; the second is fresh
         @(posedge pclk);
         if (!dual) begin
            repeat (2) @(posedge pclk iff v_odd);
            cmpw("single bus word", pack(p[i], jeida & d24), w_odd, d24);
            chk("even bus idle", 32'h0, {27'h0, lvds_even});
         end else if (i == 1) begin
            repeat (2) @(posedge pclk iff v_even);
            cmpw("odd bus word", pack(p[0], jeida & d24), w_odd, d24);
            cmpw("even bus word", pack(p[1], jeida & d24), w_even, d24);
         end
      end
   endtask
   // Every bus count and format through the control register
   task automatic scen_reg_modes();
      logic [31:0] c;
      for (int m = 0; m < 6; m++) begin
         c = 32'(1 + (m / 3) * 2 + (m % 3) * 4);
         apb(1'b1, LPP_ADDR_CTRL, c);
         chk("ctrl write error", 32'h0, {31'h0, er});
         apb(1'b0, LPP_ADDR_CTRL, 32'h0);
         chk("ctrl readback", c, rd);
         apb(1'b0, LPP_ADDR_STAT, 32'h0);
         chk("effective mode", {29'h0, c[3:1]}, {29'h0, rd[5:3]});
         run_pixels(m % 3 == 1, m % 3 != 2, m >= 3);
      end
   endtask
   task automatic scen_apb_errors();
      apb(1'b0, LPP_VENDOR_BASE + 12'h008, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      chk("unmapped data", LPP_ERR_DATA, rd);
      apb(1'b1, LPP_ADDR_STAT, 32'hFFFFFFFF);
      chk("status write error", 32'h1, {31'h0, er});
   endtask
   task automatic wake();
      @(posedge pclk);
      wake_pulse <= 1'b1;
      repeat (2) @(posedge pclk);
      wake_pulse <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   // Straps hold until a wake, and are ignored while scan select is high
   task automatic scen_straps();
      apb(1'b1, LPP_ADDR_CTRL, 32'h0);
      bus_count_strap <= 1'b1;
      apb(1'b0, LPP_ADDR_STAT, 32'h0);
      chk("strap held", 32'h0, {31'h0, rd[0]});
      scan_select_input <= 1'b1;
      wake();
      apb(1'b0, LPP_ADDR_STAT, 32'h0);
      chk("strap in scan", 32'h0, {31'h0, rd[0]});
      scan_select_input <= 1'b0;
      wake();
      apb(1'b0, LPP_ADDR_STAT, 32'h0);
      chk("strap on wake", 32'h1, {31'h0, rd[0]});
      run_pixels(1'b0, 1'b1, 1'b1);
      format_depth_strap <= LPP_FMT_18;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, LPP_ADDR_STAT, 32'h0);
      chk("strap at reset", {29'h0, LPP_FMT_18, 1'b1}, {29'h0, rd[5:3]});
      run_pixels(1'b0, 1'b0, 1'b1);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      run_pixels(1'b0, 1'b1, 1'b0);
      scen_apb_errors();
      scen_reg_modes();
      spread_on = 1'b1;
      apb(1'b1, LPP_ADDR_CTRL, 32'h13);
      run_pixels(1'b0, 1'b1, 1'b1);
      spread_on = 1'b0;
      scen_straps();
      chk("early clock edges", 32'h0, 32'(e_odd + e_even));
      give_verdict();
   end
endmodule
`default_nettype wire
